// ### rtl/isr_pkg.sv
package isr_pkg;

  // Slave addressing.
  localparam logic [6:0] ISR_SLAVE_ADDR    = 7'h2a;
  localparam logic [7:0] ISR_WR_ADDR_BYTE  = 8'h54;
  localparam logic [7:0] ISR_RD_ADDR_BYTE  = 8'h55;

  // Register offsets.
  localparam logic [7:0] ISR_REG_ID        = 8'h00;
  localparam logic [7:0] ISR_REG_UV_CFG    = 8'h1e;
  localparam logic [7:0] ISR_REG_PWR_CMD   = 8'h1f;
  localparam logic [7:0] ISR_REG_LAST      = 8'h1f;

  // Field positions and reset values.
  localparam int         ISR_UV_LIN_BIT    = 0;
  localparam int         ISR_UV_CONV_BIT   = 1;
  localparam logic       ISR_UV_LIN_RST    = 1'b0;
  localparam logic [7:0] ISR_PWR_CMD_RST   = 8'h00;
  // Identification value is arbitrary.
  localparam logic [7:0] ISR_CHIP_ID       = 8'h5a;
  // Power-off command value is a plain default, overridable per instance.
  localparam logic [7:0] ISR_SHUTDOWN_CODE = 8'hb2;

  // Timing: quarter of the fastest legal serial clock period, rounded up.
  localparam int         ISR_CLK_KHZ       = 50000;
  localparam int         ISR_SCL_MAX_KHZ   = 400;
  localparam int         ISR_QTR_CYC       = (ISR_CLK_KHZ + 4 * ISR_SCL_MAX_KHZ - 1)
                                             / (4 * ISR_SCL_MAX_KHZ);

  // Host command buffer.
  localparam int         ISR_CMD_W         = 17;
  localparam int         ISR_FIFO_DEPTH    = 8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_REG    = 3'b010,
    ST_WDATA  = 3'b011,
    ST_RDATA  = 3'b100,
    ST_IGNORE = 3'b101
  } isr_dev_state_t;

  typedef enum logic [1:0] {
    SY_IDLE  = 2'b00,
    SY_START = 2'b01,
    SY_BYTE  = 2'b10,
    SY_STOP  = 2'b11
  } isr_sym_t;

endpackage

// ### rtl/isr_link_if.sv
`timescale 1ns/1ps
interface isr_link_if;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic scl;
  logic sda;

  // Open-drain wires with pullups: a line is low only while someone drives it low.
  assign scl = (dev_scl_oe_n | dev_scl_o) & (host_scl_oe_n | host_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);

  modport dev  (input scl, sda, output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n);
  modport host (input scl, sda, output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface

// ### rtl/isr_device.sv
`timescale 1ns/1ps
module isr_device
  import isr_pkg::*;
#(
  parameter logic [7:0] SHUTDOWN_CODE = ISR_SHUTDOWN_CODE
)
(
  // Clock, reset and enable.
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  // Serial link.
  isr_link_if.dev   link,
  // Power control pins.
  input  wire logic wake_n_i,
  input  wire logic conv_uvlo_src_i,
  // Register outputs.
  output logic      linear_reg_uvlo_source_select_o,
  output logic      converter_uvlo_source_select_o,
  output logic      off_mode_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, a level is accepted once stages two and
  // three agree, which also rejects single-cycle glitches on the bus.

  logic [3:0] raw_in;
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] lvl_ff;
  assign raw_in = {conv_uvlo_src_i, wake_n_i, link.sda, link.scl};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        s1_ff[i]  <= 1'b1;
        s2_ff[i]  <= 1'b1;
        s3_ff[i]  <= 1'b1;
        lvl_ff[i] <= 1'b1;
      end else if (ce_i) begin
        s1_ff[i] <= raw_in[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus event detection.

  logic scl_q_ff;
  logic sda_q_ff;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_lvl   = lvl_ff[0];
  assign sda_lvl   = lvl_ff[1];
  assign scl_rise  = scl_lvl & ~scl_q_ff;
  assign scl_fall  = ~scl_lvl & scl_q_ff;
  assign start_det = scl_lvl & scl_q_ff & sda_q_ff & ~sda_lvl;
  assign stop_det  = scl_lvl & scl_q_ff & ~sda_q_ff & sda_lvl;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else if (ce_i) begin
      scl_q_ff <= scl_lvl;
      sda_q_ff <= sda_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic           lin_sel_ff;
  logic [7:0]     pwr_cmd_ff;
  logic           off_ff;
  isr_dev_state_t state_ff;
  logic [3:0]     cnt_ff;
  logic [7:0]     rx_ff;
  logic [7:0]     tx_ff;
  logic [7:0]     ptr_ff;
  logic           rw_ff;
  logic           mack_ff;
  logic           sda_oe_n_ff;
  logic           scl_oe_n_ff;
  logic           drv_lvl_ff;
  logic           wr_stb;
  logic [7:0]     nxt_ptr;
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic conv,
                                          input logic lin, input logic [7:0] pwr);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ISR_REG_ID:      v = ISR_CHIP_ID;
      ISR_REG_UV_CFG: begin
        v[ISR_UV_CONV_BIT] = conv;
        v[ISR_UV_LIN_BIT]  = lin;
      end
      ISR_REG_PWR_CMD: v = pwr;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  assign wr_stb   = scl_fall && (cnt_ff == 4'h8) && (state_ff == ST_WDATA);
  // Register 0x00 is a fixed window: repeated accesses stay on it.
  assign nxt_ptr  = (ptr_ff == ISR_REG_ID) ? ptr_ff : ptr_ff + 8'h01;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lin_sel_ff <= ISR_UV_LIN_RST;
      pwr_cmd_ff <= ISR_PWR_CMD_RST;
    end else if (ce_i && wr_stb) begin
      if (ptr_ff == ISR_REG_UV_CFG) begin
        lin_sel_ff <= rx_ff[ISR_UV_LIN_BIT];
      end
      if (ptr_ff == ISR_REG_PWR_CMD) begin
        pwr_cmd_ff <= rx_ff;
      end
    end
  end
  // Off mode is left only through a low wake pin; a command written in the
  // same cycle as a wake wins, so the shutdown request is never lost.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      off_ff <= 1'b0;
    end else if (ce_i) begin
      if (wr_stb && ptr_ff == ISR_REG_PWR_CMD && rx_ff == SHUTDOWN_CODE) begin
        off_ff <= 1'b1;
      end else if (!lvl_ff[2]) begin
        off_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol engine. Sampling on synchronised edges adds about four cycles of
  // delay, far below a quarter of the fastest legal clock period.

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= 4'h0;
      rx_ff       <= 8'h00;
      tx_ff       <= 8'hff;
      ptr_ff      <= 8'h00;
      rw_ff       <= 1'b0;
      mack_ff     <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else if (ce_i) begin
      if (start_det) begin
        state_ff    <= ST_ADDR;
        cnt_ff      <= 4'h0;
        sda_oe_n_ff <= 1'b1;
      end else if (stop_det) begin
        state_ff    <= ST_IDLE;
        sda_oe_n_ff <= 1'b1;
      end else if (state_ff != ST_IDLE && state_ff != ST_IGNORE) begin
        if (scl_rise) begin
          if (cnt_ff < 4'h8) begin
            rx_ff <= {rx_ff[6:0], sda_lvl};
            tx_ff <= {tx_ff[6:0], 1'b1};
          end else begin
            mack_ff <= ~sda_lvl;
          end
          cnt_ff <= cnt_ff + 4'h1;
        end else if (scl_fall) begin
          case (cnt_ff)
            4'h8: begin
              sda_oe_n_ff <= 1'b1;
              case (state_ff)
                ST_ADDR: begin
                  if (rx_ff[7:1] == ISR_SLAVE_ADDR) begin
                    sda_oe_n_ff <= 1'b0;
                    rw_ff       <= rx_ff[0];
                  end else begin
                    state_ff <= ST_IGNORE;
                  end
                end
                ST_REG: begin
                  if (rx_ff <= ISR_REG_LAST) begin
                    sda_oe_n_ff <= 1'b0;
                    ptr_ff      <= rx_ff;
                  end else begin
                    state_ff <= ST_IGNORE;
                  end
                end
                ST_WDATA: begin
                  sda_oe_n_ff <= 1'b0;
                  ptr_ff      <= nxt_ptr;
                end
                default: sda_oe_n_ff <= 1'b1;
              endcase
            end
            4'h9: begin
              cnt_ff      <= 4'h0;
              sda_oe_n_ff <= 1'b1;
              case (state_ff)
                ST_ADDR: begin
                  if (rw_ff) begin
                    state_ff    <= ST_RDATA;
                    tx_ff       <= reg_read(ptr_ff, lvl_ff[3], lin_sel_ff, pwr_cmd_ff);
                    sda_oe_n_ff <= 1'(reg_read(ptr_ff, lvl_ff[3], lin_sel_ff, pwr_cmd_ff) >> 7);
                  end else begin
                    state_ff <= ST_REG;
                  end
                end
                ST_REG: state_ff <= ST_WDATA;
                ST_RDATA: begin
                  if (mack_ff) begin
                    ptr_ff      <= nxt_ptr;
                    tx_ff       <= reg_read(nxt_ptr, lvl_ff[3], lin_sel_ff, pwr_cmd_ff);
                    sda_oe_n_ff <= 1'(reg_read(nxt_ptr, lvl_ff[3], lin_sel_ff, pwr_cmd_ff) >> 7);
                  end else begin
                    state_ff <= ST_IGNORE;
                  end
                end
                default: state_ff <= state_ff;
              endcase
            end
            default: sda_oe_n_ff <= (state_ff == ST_RDATA) ? tx_ff[7] : 1'b1;
          endcase
        end
      end else begin
        sda_oe_n_ff <= 1'b1;
      end
    end
  end

  // The clock line is never stretched, so any master rate up to the limit works.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_oe_n_ff <= 1'b1;
      drv_lvl_ff  <= 1'b0;
    end else if (ce_i) begin
      scl_oe_n_ff <= 1'b1;
      drv_lvl_ff  <= 1'b0;
    end
  end

  assign link.dev_scl_o                  = drv_lvl_ff;
  assign link.dev_scl_oe_n               = scl_oe_n_ff;
  assign link.dev_sda_o                  = drv_lvl_ff;
  assign link.dev_sda_oe_n               = sda_oe_n_ff;
  assign linear_reg_uvlo_source_select_o = lin_sel_ff;
  assign converter_uvlo_source_select_o  = lvl_ff[3];
  assign off_mode_o                      = off_ff;
endmodule

// ### rtl/isr_host.sv
`timescale 1ns/1ps
module isr_fifo
  import isr_pkg::*;
#(
  parameter int WIDTH = ISR_CMD_W,
  parameter int DEPTH = ISR_FIFO_DEPTH
)
(
  // Clock, reset and enable.
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  // Fill side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             rdy_ff;
  logic             push;
  logic             pop;

  assign push        = in_valid_i & rdy_ff;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem[rp_ff];
  assign in_ready_o  = rdy_ff;
  assign nxt_cnt     = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wp_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end else if (ce_i) begin
      wp_ff  <= wp_ff + AW'(push);
      rp_ff  <= rp_ff + AW'(pop);
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt != (AW+1)'(DEPTH));
    end
  end
endmodule

module isr_host
  import isr_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  // Serial link.
  isr_link_if.host        link,
  // Command port.
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_read_i,
  input  wire logic [7:0] cmd_reg_i,
  input  wire logic [7:0] cmd_data_i,
  // Result port.
  output logic            done_o,
  output logic            nack_o,
  output logic [7:0]      rd_data_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Command buffer and input synchronisers.

  logic                 q_valid;
  logic                 q_ready;
  logic [ISR_CMD_W-1:0] q_data;
  logic [1:0]           s1_ff;
  logic [1:0]           s2_ff;
  logic [1:0]           s3_ff;
  logic [1:0]           lvl_ff;
  logic [1:0]           raw_in;

  isr_fifo #(.WIDTH(ISR_CMD_W), .DEPTH(ISR_FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_valid_i  (cmd_valid_i),
    .in_ready_o  (cmd_ready_o),
    .in_data_i   ({cmd_read_i, cmd_reg_i, cmd_data_i}),
    .out_valid_o (q_valid),
    .out_ready_i (q_ready),
    .out_data_o  (q_data)
  );

  assign raw_in = {link.sda, link.scl};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        s1_ff[i]  <= 1'b1;
        s2_ff[i]  <= 1'b1;
        s3_ff[i]  <= 1'b1;
        lvl_ff[i] <= 1'b1;
      end else if (ce_i) begin
        s1_ff[i] <= raw_in[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: each bit slot spans four quarters, nine slots per byte symbol; SDA only moves while SCL is low,
  // except inside start and stop symbols where that move is the condition.

  isr_sym_t   sym_ff;
  logic [5:0] qcnt_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic [8:0] sh_ff;
  logic [8:0] rx_ff;
  logic [2:0] stage_ff;
  logic       rd_ff;
  logic [7:0] reg_ff;
  logic [7:0] dat_ff;
  logic       scl_oe_n_ff;
  logic       sda_oe_n_ff;
  logic       drv_lvl_ff;
  logic       done_ff;
  logic       nack_ff;
  logic [7:0] rdat_ff;
  logic       tick;
  logic       sym_end;

  assign q_ready = (sym_ff == SY_IDLE);
  assign tick    = (qcnt_ff == 6'(ISR_QTR_CYC - 1));
  assign sym_end = tick && (q_ff == 2'd3) && (sym_ff != SY_BYTE || bit_ff == 4'h8);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sym_ff      <= SY_IDLE;
      qcnt_ff     <= 6'h00;
      q_ff        <= 2'd0;
      bit_ff      <= 4'h0;
      sh_ff       <= 9'h1ff;
      rx_ff       <= 9'h1ff;
      stage_ff    <= 3'd0;
      rd_ff       <= 1'b0;
      reg_ff      <= 8'h00;
      dat_ff      <= 8'h00;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      drv_lvl_ff  <= 1'b0;
      done_ff     <= 1'b0;
      nack_ff     <= 1'b0;
      rdat_ff     <= 8'h00;
    end else if (ce_i) begin
      done_ff    <= 1'b0;
      drv_lvl_ff <= 1'b0;
      if (sym_ff == SY_IDLE) begin
        qcnt_ff <= 6'h00;
        q_ff    <= 2'd0;
        if (q_valid) begin
          {rd_ff, reg_ff, dat_ff} <= q_data;
          sym_ff   <= SY_START;
          stage_ff <= 3'd0;
          nack_ff  <= 1'b0;
        end
      end else begin
        qcnt_ff <= tick ? 6'h00 : qcnt_ff + 6'h01;
        if (tick) begin
          q_ff <= q_ff + 2'd1;
          case (q_ff)
            2'd0: scl_oe_n_ff <= 1'b0;
            2'd1: sda_oe_n_ff <= (sym_ff == SY_BYTE) ? sh_ff[8] : (sym_ff == SY_STOP) ? 1'b0 : 1'b1;
            2'd2: scl_oe_n_ff <= 1'b1;
            default: begin
              if (sym_ff == SY_BYTE) begin
                rx_ff  <= {rx_ff[7:0], lvl_ff[1]};
                sh_ff  <= {sh_ff[7:0], 1'b1};
                bit_ff <= bit_ff + 4'h1;
              end else begin
                sda_oe_n_ff <= (sym_ff == SY_STOP);
              end
            end
          endcase
        end
        if (sym_end) begin
          bit_ff <= 4'h0;
          case (stage_ff)
            3'd0: begin
              sym_ff   <= SY_BYTE;
              sh_ff    <= {ISR_WR_ADDR_BYTE, 1'b1};
              stage_ff <= 3'd1;
            end
            3'd1, 3'd2, 3'd4: begin
              if (lvl_ff[1]) begin
                nack_ff  <= 1'b1;
                sym_ff   <= SY_STOP;
                stage_ff <= 3'd7;
              end else if (stage_ff == 3'd1) begin
                sym_ff   <= SY_BYTE;
                sh_ff    <= {reg_ff, 1'b1};
                stage_ff <= 3'd2;
              end else if (stage_ff == 3'd2 && rd_ff) begin
                sym_ff   <= SY_START;
                stage_ff <= 3'd3;
              end else if (stage_ff == 3'd2) begin
                sym_ff   <= SY_BYTE;
                sh_ff    <= {dat_ff, 1'b1};
                stage_ff <= 3'd5;
              end else begin
                sym_ff   <= SY_BYTE;
                sh_ff    <= 9'h1ff;
                stage_ff <= 3'd6;
              end
            end
            3'd3: begin
              sym_ff   <= SY_BYTE;
              sh_ff    <= {ISR_RD_ADDR_BYTE, 1'b1};
              stage_ff <= 3'd4;
            end
            3'd5, 3'd6: begin
              if (stage_ff == 3'd5) begin
                nack_ff <= lvl_ff[1];
              end else begin
                rdat_ff <= rx_ff[7:0];
              end
              sym_ff   <= SY_STOP;
              stage_ff <= 3'd7;
            end
            default: begin
              sym_ff  <= SY_IDLE;
              done_ff <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  assign link.host_scl_o    = drv_lvl_ff;
  assign link.host_scl_oe_n = scl_oe_n_ff;
  assign link.host_sda_o    = drv_lvl_ff;
  assign link.host_sda_oe_n = sda_oe_n_ff;
  assign done_o             = done_ff;
  assign nack_o             = nack_ff;
  assign rd_data_o          = rdat_ff;

endmodule

// ### sim/isr_link_monitor.sv
`timescale 1ns/1ps
module isr_link_monitor
  import isr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Link signals.
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_ff;
  logic       sda_ff;
  logic [3:0] cnt_ff;
  logic [2:0] byte_ff;
  logic [7:0] sh_ff;
  logic       wr_ff;
  logic       rd_ff;
  logic       ok_ff;
  wire        rise     = scl & ~scl_ff;
  wire        start    = scl & scl_ff & sda_ff & ~sda;
  wire        stop     = scl & scl_ff & ~sda_ff & sda;
  wire        ninth    = rise & (cnt_ff == 4'h8);
  wire        addr_hit = (sh_ff[7:1] == ISR_SLAVE_ADDR);
  wire        reg_bad  = (sh_ff > ISR_REG_LAST);
  wire        rd_nack  = rd_ff & (byte_ff == 3'h1) & (cnt_ff == 4'h8) & sda;

  ////////////////////////////////////////
  // Raw line edges are good enough here: the device resamples through its own syncs.
  always_ff @(posedge clk_i) begin
    scl_ff <= srst_i | scl;
    sda_ff <= srst_i | sda;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i | start | stop) begin
      cnt_ff  <= 4'h0;
      byte_ff <= 3'h0;
    end else if (ninth) begin
      cnt_ff  <= 4'h0;
      byte_ff <= byte_ff + 3'h1;
    end else if (rise) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rise & (cnt_ff < 4'h8)) begin
      sh_ff <= {sh_ff[6:0], sda};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i | start) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end else if (ninth & (byte_ff == 3'h0)) begin
      wr_ff <= (sh_ff == ISR_WR_ADDR_BYTE);
      rd_ff <= (sh_ff == ISR_RD_ADDR_BYTE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i | start) begin
      ok_ff <= 1'b0;
    end else if (ninth & (byte_ff == 3'h1) & wr_ff) begin
      ok_ff <= ~reg_bad;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_scl_released: assert property (dev_scl_oe_n)
    else $error("device drove the clock line");
  a_drive_low: assert property (!dev_sda_oe_n |-> !dev_sda_o)
    else $error("device drove data high");
  a_hold_high: assert property (scl && scl_ff |-> $stable(dev_sda_oe_n))
    else $error("device data moved while clock high");
  a_addr_listen: assert property (byte_ff == 3'h0 && cnt_ff != 4'h8 |-> dev_sda_oe_n)
    else $error("device drove data inside the address byte");
  a_addr_ack: assert property (ninth && byte_ff == 3'h0 |-> dev_sda_oe_n == !addr_hit)
    else $error("wrong answer to slave address");
  a_reg_ack: assert property (ninth && byte_ff == 3'h1 && wr_ff |-> dev_sda_oe_n == reg_bad)
    else $error("wrong answer to register address");
  a_data_ack: assert property (ninth && byte_ff == 3'h2 && wr_ff && ok_ff |-> !dev_sda_oe_n)
    else $error("write data not acknowledged");
  a_nack_release: assert property ($rose(scl) && rd_nack |=> dev_sda_oe_n [*8])
    else $error("device kept driving after master nack");
  a_stop_release: assert property (stop |=> dev_sda_oe_n [*8])
    else $error("device drove data after stop");
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import isr_pkg::*;

  logic       clk         = 1'b0;
  logic       srst        = 1'b1;
  logic       ce          = 1'b1;
  logic       cmd_valid   = 1'b0;
  logic       cmd_read    = 1'b0;
  logic [7:0] cmd_reg     = 8'h00;
  logic [7:0] cmd_data    = 8'h00;
  logic       wake_n      = 1'b1;
  logic       conv_src    = 1'b0;
  logic       cmd_ready;
  logic       done;
  logic       nack;
  logic [7:0] rd_data;
  logic       lin_sel;
  logic       conv_sel;
  logic       off_mode;
  logic       saw_full    = 1'b0;
  logic       uv_lin      = 1'b0;
  logic [7:0] pwr_val     = 8'h00;
  logic [7:0] last_rd     = 8'h00;
  logic [7:0] wval;
  logic [8:0] exp_q[$];
  int         error_cnt   = 0;
  int         checks_done = 0;

  always #10 clk = ~clk;

  isr_link_if isr_link_if_i ();
  isr_host isr_host_i (.clk_i(clk), .srst_i(srst), .ce_i(ce), .link(isr_link_if_i.host),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read),
    .cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data), .done_o(done), .nack_o(nack),
    .rd_data_o(rd_data));
  isr_device isr_device_i (.clk_i(clk), .srst_i(srst), .ce_i(ce), .link(isr_link_if_i.dev),
    .wake_n_i(wake_n), .conv_uvlo_src_i(conv_src), .linear_reg_uvlo_source_select_o(lin_sel),
    .converter_uvlo_source_select_o(conv_sel), .off_mode_o(off_mode));
  isr_link_monitor isr_link_monitor_i (.clk_i(clk), .srst_i(srst),
    .dev_scl_oe_n(isr_link_if_i.dev_scl_oe_n), .dev_sda_o(isr_link_if_i.dev_sda_o),
    .dev_sda_oe_n(isr_link_if_i.dev_sda_oe_n), .scl(isr_link_if_i.scl),
    .sda(isr_link_if_i.sda));

  ////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Result of a read: nack flag above the data that rd_data_o should then show.
  function automatic logic [8:0] expect_rd(input logic [7:0] rg);
    if (rg > ISR_REG_LAST) return {1'b1, last_rd};
    if (rg == ISR_REG_ID) return {1'b0, ISR_CHIP_ID};
    if (rg == ISR_REG_UV_CFG) return {7'h00, conv_src, uv_lin};
    if (rg == ISR_REG_PWR_CMD) return {1'b0, pwr_val};
    return 9'h000;
  endfunction

  // Valid is left high so back-to-back pushes keep the FIFO under pressure.
  task automatic push(input logic rd, input logic [7:0] rg, input logic [7:0] dt);
    logic [8:0] e;
    logic       ok;
    e = rd ? expect_rd(rg) : {rg > ISR_REG_LAST, last_rd};
    if (rd && !e[8]) last_rd = e[7:0];
    if (!rd && rg == ISR_REG_UV_CFG) uv_lin = dt[0];
    if (!rd && rg == ISR_REG_PWR_CMD) pwr_val = dt;
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_reg   <= rg;
    cmd_data  <= dt;
    do begin
      @(negedge clk);
      ok = (cmd_ready === 1'b1);
      saw_full |= !ok;
      @(posedge clk);
    end while (!ok);
    exp_q.push_back(e);
  endtask

  task automatic drain();
    cmd_valid <= 1'b0;
    for (int i = 0; i < 80000 && exp_q.size() != 0; i++) @(posedge clk);
    @(negedge clk);
    check(9'(exp_q.size()), 9'h000);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(negedge clk) begin
    if (done === 1'b1 && exp_q.size() != 0) begin
      check({nack, rd_data}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h4e40));
    conv_src <= 1'($urandom_range(1, 0));
    wval = 8'($urandom_range(255, 0));
    if (wval == ISR_SHUTDOWN_CODE) wval = ~wval;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    push(1'b1, ISR_REG_ID, 8'h00);
    push(1'b1, ISR_REG_UV_CFG, 8'h00);
    push(1'b1, ISR_REG_PWR_CMD, 8'h00);
    push(1'b0, ISR_REG_PWR_CMD, wval);
    push(1'b1, ISR_REG_PWR_CMD, 8'h00);
    push(1'b0, ISR_REG_UV_CFG, 8'hff);
    push(1'b1, ISR_REG_UV_CFG, 8'h00);
    push(1'b1, 8'h20 + 8'($urandom_range(223, 0)), 8'h00);
    push(1'b0, 8'h20, wval);
    push(1'b1, ISR_REG_ID, 8'h00);
    drain();
    check({8'h00, saw_full}, 9'h001);
    check({7'h00, conv_sel, lin_sel}, {7'h00, conv_src, 1'b1});
    $display("test register traffic done");
    push(1'b0, ISR_REG_PWR_CMD, ISR_SHUTDOWN_CODE);
    cmd_valid <= 1'b0;
    // Freeze both ends in mid-symbol; the transfer must resume where it stopped.
    repeat (100) @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    drain();
    check({8'h00, off_mode}, 9'h001);
    @(posedge clk);
    wake_n <= 1'b0;
    repeat (8) @(posedge clk);
    wake_n <= 1'b1;
    repeat (4) @(negedge clk);
    check({8'h00, off_mode}, 9'h000);
    $display("test shutdown and wake done");
    end_of_test();
  end
endmodule
